// ### rtl/sar_adc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
// What this block does
// - Start from software, timer 2, timer 3, pin.
// - Completion raises interrupt and pollable status bit.
// - Latch result into two byte registers.
// - Software selects right or left justification.
// - Window compare raises interrupt only inside window.
// - Nine channels, one is temperature sensor.
// - Adjacent external pairs selectable as differential input.
// - Gain selectable 0.5 to 16, six settings.
// - Shutdown bit stops all conversions.
// - Result formatting follows 10 or 12 bit width.
// - Sequencing needs 2001 clocks per conversion, just under 100 ksps continuous triggering.
// - Converter keeps running while core is halted.
// - External start comes from crossbar routed pin.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH
`define ADC_CTRL_OFS 8'h00
`define ADC_CHAN_OFS 8'h04
`define ADC_RES_LO_OFS 8'h08
`define ADC_RES_HI_OFS 8'h0C
`define ADC_WIN_LO_LO_OFS 8'h10
`define ADC_WIN_LO_HI_OFS 8'h14
`define ADC_WIN_HI_LO_OFS 8'h18
`define ADC_WIN_HI_HI_OFS 8'h1C
`define ADC_STAT_OFS 8'h20
`define ADC_CLR_OFS 8'h24
`define ADC_IEN_OFS 8'h28
`define ADC_START_OFS 8'h2C
`define CTRL_EN_BIT 0
`define CTRL_LJST_BIT 1
`define CTRL_WIN_BIT 2
`define CTRL_SRC_LSB 3
`define CTRL_GAIN_LSB 5
`define CTRL_RESET 8'h00
`define CHAN_RESET 8'h00
`define GAIN_RESET 3'h2
`define STAT_DONE_BIT 0
`define STAT_WIN_BIT 1
`define CONV_RATE_KSPS 100
`define CLK_MHZ 200
`define CONV_CYCLES ((`CLK_MHZ * 1000) / `CONV_RATE_KSPS)
`endif

// ### rtl/sar_adc_pkg.sv
// Types shared by the converter control files.
package sar_adc_pkg;
	typedef enum logic [1:0] {
		SRC_SOFT,
		SRC_TMR2,
		SRC_TMR3,
		SRC_PIN
	} start_src_e;
	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_BUSY,
		CONV_DONE
	} conv_state_e;
endpackage

// ### rtl/sar_adc_format.sv
// Result justification and window comparison for the converter control.
`timescale 1ns/1ps
module sar_adc_format #(
	parameter int RES_BITS = 12
) (
	input wire logic [RES_BITS-1:0] raw_i,
	input wire logic left_i,
	input wire logic [15:0] win_lo_i,
	input wire logic [15:0] win_hi_i,
	output logic [15:0] word_o,
	output logic in_win_o
);
	always_comb begin
		if (left_i) begin
			word_o = {raw_i, {(16-RES_BITS){1'b0}}};
		end else begin
			word_o = {{(16-RES_BITS){1'b0}}, raw_i};
		end
		in_win_o = (word_o >= win_lo_i) && (word_o <= win_hi_i);
	end
endmodule // sar_adc_format

// ### rtl/sar_adc_sequencer.sv
// Converter control: register slave, start selection, conversion sequencing and result latch.
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module sar_adc_sequencer #(
	parameter int RES_BITS = 12,
	parameter int CONV_CYCLES = `CONV_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic tmr2_ovf_i,
	input wire logic tmr3_ovf_i,
	input wire logic ext_start_i,
	input wire logic core_halt_i,
	input wire logic [RES_BITS-1:0] conv_data_i,
	output logic [3:0] chan_sel_o,
	output logic [3:0] diff_pair_o,
	output logic [2:0] gain_o,
	output logic conv_start_o,
	output logic shutdown_o,
	output logic irq_o
);
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] chan_reg, chan_next;
	logic [15:0] result_reg, result_next;
	logic [15:0] win_lo_reg, win_lo_next;
	logic [15:0] win_hi_reg, win_hi_next;
	logic [1:0] stat_reg, stat_next;
	logic [1:0] ien_reg, ien_next;
	logic [15:0] cnt_reg, cnt_next;
	logic start_reg, start_next;
	logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
	sar_adc_pkg::conv_state_e state_reg, state_next;
	logic wr, rd_ok, trig, done_evt, win_evt, in_win;
	logic [15:0] word;
	logic [1:0] clr_bits;
	logic [7:0] wb;

	sar_adc_format #(
		.RES_BITS(RES_BITS)
	) u_format (
		.raw_i(conv_data_i),
		.left_i(ctrl_reg[`CTRL_LJST_BIT]),
		.win_lo_i(win_lo_reg),
		.win_hi_i(win_hi_reg),
		.word_o(word),
		.in_win_o(in_win)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_start_i;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	always_comb begin
		wr = cyc_i && stb_i && we_i && !ack_reg && sel_i[0];
		wb = dat_i[7:0];
		case (sar_adc_pkg::start_src_e'(ctrl_reg[`CTRL_SRC_LSB +: 2]))
			sar_adc_pkg::SRC_SOFT: trig = wr && (adr_i == `ADC_START_OFS) && wb[0];
			sar_adc_pkg::SRC_TMR2: trig = tmr2_ovf_i;
			sar_adc_pkg::SRC_TMR3: trig = tmr3_ovf_i;
			default: trig = ext_s2_reg && !ext_s3_reg;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		start_next = 1'b0;
		result_next = result_reg;
		done_evt = 1'b0;
		win_evt = 1'b0;
		case (state_reg)
			sar_adc_pkg::CONV_IDLE: begin
				if (trig && ctrl_reg[`CTRL_EN_BIT]) begin
					state_next = sar_adc_pkg::CONV_BUSY;
					cnt_next = 16'(CONV_CYCLES - 2);
					start_next = 1'b1;
				end
			end
			sar_adc_pkg::CONV_BUSY: begin
				if (!ctrl_reg[`CTRL_EN_BIT]) begin
					state_next = sar_adc_pkg::CONV_IDLE;
				end else if (cnt_reg == 16'h0000) begin
					state_next = sar_adc_pkg::CONV_DONE;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			default: begin
				result_next = word;
				done_evt = 1'b1;
				win_evt = ctrl_reg[`CTRL_WIN_BIT] && in_win;
				state_next = sar_adc_pkg::CONV_IDLE;
			end
		endcase
	end

	always_comb begin
		ack_next = cyc_i && stb_i && !ack_reg;
		ctrl_next = ctrl_reg;
		chan_next = chan_reg;
		win_lo_next = win_lo_reg;
		win_hi_next = win_hi_reg;
		ien_next = ien_reg;
		clr_bits = 2'b00;
		if (wr) begin
			if (adr_i == `ADC_CTRL_OFS) begin
				ctrl_next = wb;
			end else if (adr_i == `ADC_CHAN_OFS) begin
				chan_next = wb;
			end else if (adr_i == `ADC_WIN_LO_LO_OFS) begin
				win_lo_next[7:0] = wb;
			end else if (adr_i == `ADC_WIN_LO_HI_OFS) begin
				win_lo_next[15:8] = wb;
			end else if (adr_i == `ADC_WIN_HI_LO_OFS) begin
				win_hi_next[7:0] = wb;
			end else if (adr_i == `ADC_WIN_HI_HI_OFS) begin
				win_hi_next[15:8] = wb;
			end else if (adr_i == `ADC_CLR_OFS) begin
				clr_bits = wb[1:0];
			end else if (adr_i == `ADC_IEN_OFS) begin
				ien_next = wb[1:0];
			end
		end
		if (ctrl_next[`CTRL_GAIN_LSB +: 3] > 3'h5) begin
			ctrl_next[`CTRL_GAIN_LSB +: 3] = 3'h5;
		end
		stat_next = (stat_reg & ~clr_bits) | {win_evt, done_evt};
		rd_ok = 1'b1;
		dat_next = 32'h0000_0000;
		if (adr_i == `ADC_CTRL_OFS) begin
			dat_next[7:0] = ctrl_reg;
		end else if (adr_i == `ADC_CHAN_OFS) begin
			dat_next[7:0] = chan_reg;
		end else if (adr_i == `ADC_RES_LO_OFS) begin
			dat_next[7:0] = result_reg[7:0];
		end else if (adr_i == `ADC_RES_HI_OFS) begin
			dat_next[7:0] = result_reg[15:8];
		end else if (adr_i == `ADC_WIN_LO_LO_OFS) begin
			dat_next[7:0] = win_lo_reg[7:0];
		end else if (adr_i == `ADC_WIN_LO_HI_OFS) begin
			dat_next[7:0] = win_lo_reg[15:8];
		end else if (adr_i == `ADC_WIN_HI_LO_OFS) begin
			dat_next[7:0] = win_hi_reg[7:0];
		end else if (adr_i == `ADC_WIN_HI_HI_OFS) begin
			dat_next[7:0] = win_hi_reg[15:8];
		end else if (adr_i == `ADC_STAT_OFS) begin
			dat_next[1:0] = stat_reg;
			dat_next[2] = (state_reg != sar_adc_pkg::CONV_IDLE);
		end else if (adr_i == `ADC_IEN_OFS) begin
			dat_next[1:0] = ien_reg;
		end else begin
			rd_ok = 1'b0;
		end
		if (!rd_ok) begin
			dat_next = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			ctrl_reg <= `CTRL_RESET;
			chan_reg <= `CHAN_RESET;
			result_reg <= 16'h0000;
			win_lo_reg <= 16'h0000;
			win_hi_reg <= 16'hFFFF;
			stat_reg <= 2'b00;
			ien_reg <= 2'b00;
			cnt_reg <= 16'h0000;
			start_reg <= 1'b0;
			state_reg <= sar_adc_pkg::CONV_IDLE;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			ctrl_reg <= ctrl_next;
			chan_reg <= chan_next;
			result_reg <= result_next;
			win_lo_reg <= win_lo_next;
			win_hi_reg <= win_hi_next;
			stat_reg <= stat_next;
			ien_reg <= ien_next;
			cnt_reg <= cnt_next;
			start_reg <= start_next;
			state_reg <= state_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
	assign chan_sel_o = (chan_reg[3:0] > 4'h8) ? 4'h8 : chan_reg[3:0];
	assign diff_pair_o = chan_reg[7:4];
	assign gain_o = ctrl_reg[`CTRL_GAIN_LSB +: 3];
	assign conv_start_o = start_reg;
	assign shutdown_o = !ctrl_reg[`CTRL_EN_BIT];
	assign irq_o = |(stat_reg & ien_reg);
endmodule // sar_adc_sequencer

// ### tb/sar_adc_properties.sv
// Port checks of the converter control.
`timescale 1ns/1ps
module sar_adc_properties #(
	parameter int CONV_CYCLES = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic conv_start_o,
	input wire logic shutdown_o,
	input wire logic irq_o,
	input wire logic [3:0] chan_sel_o,
	input wire logic [2:0] gain_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [15:0] gap_reg;
	// Counts the cycles after a start in which a new start would cut into the conversion.
	always_ff @(posedge clk_i) begin
		if (rst_i || shutdown_o) begin
			gap_reg <= 16'h0000;
		end else if (conv_start_o) begin
			gap_reg <= 16'(CONV_CYCLES - 1);
		end else if (gap_reg != 16'h0000) begin
			gap_reg <= gap_reg - 16'h0001;
		end
	end
	AST_ACK_ONE:
	assert property (ack_o |=> !ack_o) else $error("ack held too long");
	AST_ACK_NEXT:
	assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	AST_SHUT_IDLE:
	assert property (conv_start_o |-> !$past(shutdown_o)) else $error("start in shutdown");
	AST_START_GAP:
	assert property (gap_reg != 16'h0000 |-> !conv_start_o) else $error("restart while busy");
	AST_IRQ_RISE:
	assert property ($rose(irq_o) |-> ack_o || $past(conv_start_o, 7) || $past(conv_start_o, 8)
		|| $past(conv_start_o, 9)) else $error("irq without cause");
	AST_IRQ_FALL:
	assert property ($fell(irq_o) |-> ack_o) else $error("irq fell without access");
	AST_CHAN_MAX:
	assert property (chan_sel_o <= 4'h8) else $error("channel out of range");
	AST_GAIN_MAX:
	assert property (gain_o <= 3'h5) else $error("gain out of range");
endmodule // sar_adc_properties

// ### tb/adc_core_model.sv
// Model of the analog converter core.
`timescale 1ns/1ps
module adc_core_model (
	input wire logic clk_i,
	input wire logic conv_start_i,
	input wire logic [11:0] sample_i,
	output logic [11:0] data_o
);
	logic [11:0] held_reg = 12'h000;
	// Samples the input at the start pulse and holds the code.
	always_ff @(posedge clk_i) if (conv_start_i) held_reg <= sample_i;
	assign data_o = held_reg;
endmodule // adc_core_model

// ### tb/testbench.sv
// Self-checking bench of the converter control.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic tmr2_ovf_i = 1'b0, tmr3_ovf_i = 1'b0, ext_start_i = 1'b0, core_halt_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, rdat;
	logic [11:0] conv_data_i, sample = 12'h000;
	logic [3:0] chan_sel_o, diff_pair_o;
	logic [2:0] gain_o;
	logic ack_o, conv_start_o, shutdown_o, irq_o;
	logic [15:0] word;
	int fails = 0, n_checks = 0, cycles = 0, starts = 0;
	sar_adc_sequencer #(.RES_BITS(12), .CONV_CYCLES(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .tmr2_ovf_i(tmr2_ovf_i), .tmr3_ovf_i(tmr3_ovf_i),
		.ext_start_i(ext_start_i), .core_halt_i(core_halt_i), .conv_data_i(conv_data_i),
		.chan_sel_o(chan_sel_o), .diff_pair_o(diff_pair_o), .gain_o(gain_o),
		.conv_start_o(conv_start_o), .shutdown_o(shutdown_o), .irq_o(irq_o));
	adc_core_model core_u (.clk_i(clk_i), .conv_start_i(conv_start_o), .sample_i(sample),
		.data_o(conv_data_i));
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (conv_start_o === 1'b1) starts <= starts + 1;
		if (cycles == 3000) begin
			fails++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rdat = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic trig(input int s);
		if (s == 0) bus(1'b1, 8'h2C, 32'h1);
		else begin
			@(posedge clk_i);
			tmr2_ovf_i <= (s == 1);
			tmr3_ovf_i <= (s == 2);
			ext_start_i <= (s == 3);
			@(posedge clk_i);
			tmr2_ovf_i <= 1'b0;
			tmr3_ovf_i <= 1'b0;
			repeat (4) @(posedge clk_i);
			ext_start_i <= 1'b0;
		end
	endtask
	task automatic conv_test();
		bus(1'b1, 8'h28, 32'h1);
		for (int s = 0; s < 4; s++) begin
			sample = 12'hA50 + 12'(s);
			bus(1'b1, 8'h00, 32'h1 | (s << 3) | ((s & 1) << 1));
			trig(s);
			trig(s);
			for (int i = 0; i < 40 && irq_o !== 1'b1; i++) @(posedge clk_i);
			`CHK("starts", s + 1, starts)
			bus(1'b0, 8'h08, 32'h0);
			word[7:0] = rdat[7:0];
			bus(1'b0, 8'h0C, 32'h0);
			word[15:8] = rdat[7:0];
			`CHK("result", (s & 1) ? {sample, 4'h0} : {4'h0, sample}, word)
			bus(1'b0, 8'h20, 32'h0);
			`CHK("done", 1'b1, rdat[0])
			bus(1'b1, 8'h24, 32'h3);
			@(posedge clk_i);
			`CHK("irq cleared", 1'b0, irq_o)
		end
	endtask
	task automatic window_test();
		bus(1'b1, 8'h28, 32'h2);
		bus(1'b1, 8'h00, 32'h5);
		bus(1'b1, 8'h18, 32'h0);
		bus(1'b1, 8'h1C, 32'h0);
		sample = 12'h123;
		trig(0);
		bus(1'b0, 8'h20, 32'h0);
		`CHK("busy", 3'b100, rdat[2:0])
		repeat (12) @(posedge clk_i);
		`CHK("irq outside", 1'b0, irq_o)
		bus(1'b0, 8'h20, 32'h0);
		`CHK("status outside", 3'b001, rdat[2:0])
		bus(1'b1, 8'h24, 32'h3);
		bus(1'b1, 8'h18, 32'hFF);
		bus(1'b1, 8'h1C, 32'hFF);
		trig(0);
		repeat (12) @(posedge clk_i);
		`CHK("irq inside", 1'b1, irq_o)
		bus(1'b0, 8'h20, 32'h0);
		`CHK("status inside", 3'b011, rdat[2:0])
	endtask
	task automatic config_test();
		bus(1'b1, 8'h00, 32'h0);
		@(posedge clk_i);
		`CHK("shutdown", 1'b1, shutdown_o)
		trig(0);
		repeat (12) @(posedge clk_i);
		`CHK("starts", 6, starts)
		bus(1'b1, 8'h04, 32'h5F);
		bus(1'b1, 8'h00, 32'hE0);
		@(posedge clk_i);
		`CHK("chan", 4'h8, chan_sel_o)
		`CHK("pairs", 4'h5, diff_pair_o)
		`CHK("gain", 3'h5, gain_o)
		bus(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rdat)
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		core_halt_i <= 1'b1;
		@(posedge clk_i);
		`CHK("reset shutdown", 1'b1, shutdown_o)
		`CHK("reset irq", 1'b0, irq_o)
		conv_test();
		window_test();
		config_test();
		finish_test();
	end
endmodule // testbench
bind sar_adc_sequencer sar_adc_properties #(.CONV_CYCLES(CONV_CYCLES)) props_u (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .conv_start_o(conv_start_o),
	.shutdown_o(shutdown_o), .irq_o(irq_o), .chan_sel_o(chan_sel_o), .gain_o(gain_o));
